// ===== rtl/relay_matrix_command_queue.sv
`timescale 1ns/1ns
module relay_matrix_command_queue
(
  input wire logic clk,                        // 10 MHz system clock
  input wire logic rst_b,                      // Async reset, active low
  input wire logic rowWrite,                   // One-cycle row register write strobe
  input wire logic writeIsClose,               // 1: close register, 0: open register
  input wire logic [1:0] writeRow,             // Row addressed
  input wire logic [15:0] writeData,           // Write data
  input wire logic [1:0] readRow,              // Row for readback
  input wire logic irqAllowBit,                // Interrupt allow control bit
  input wire logic powerEnable,                // Driver power enable control bit
  input wire logic carrierResetReq,            // Carrier reset pin, asynchronous, active high
  output logic [15:0] readData,                // Row readback
  output logic queueEmpty,                     // Queue empty flag
  output logic queueFull,                      // Queue full flag
  output logic initDone,                       // Initialisation flag
  output logic irq,                            // Interrupt toward carrier
  output logic driverPower,                    // Relay driver power switch
  output logic [3:0] rowDrive,                 // One-hot row being driven
  output logic [3:0] colDrive,                 // Column pattern being driven
  output logic driveClose                      // 1 close coils, 0 open coils
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  relay_matrix_pkg::drive_state_type state; // Drive engine state
  relay_matrix_pkg::drive_state_type next_state; // Next engine state
  logic [relay_matrix_pkg::COLS-1:0] rowState [relay_matrix_pkg::ROWS]; // Readback store
  logic [relay_matrix_pkg::TIMER_W-1:0] timer; // Drive timer
  logic [relay_matrix_pkg::ROWS-1:0] rowOpened; // Rows given all-zero open since reset
  logic carrierReset; // Synchronised carrier reset
  logic qEmpty; // Queue empty
  logic qFull; // Queue full
  logic [relay_matrix_pkg::ENTRY_W-1:0] head; // Queue head entry
  logic [relay_matrix_pkg::ENTRY_W-1:0] newEntry; // Entry built from write
  logic accept; // Write accepted into queue
  logic popHead; // Take head into drive
  logic timerDone; // Drive time expired
  logic lastDone; // Final operation finished
  logic [relay_matrix_pkg::COLS-1:0] wrCols; // Written column bits
  logic [relay_matrix_pkg::COLS-1:0] curRow; // Current value of written row
  logic [relay_matrix_pkg::COLS-1:0] next_row; // Updated value of written row
  logic [relay_matrix_pkg::COLS-1:0] headCols; // Head column bits
  logic [relay_matrix_pkg::ROW_IDX_W-1:0] headRow; // Head row index
  logic headClose; // Head is close operation
  logic initWrite; // Write forms part of initialisation
  logic [relay_matrix_pkg::COLS-1:0] next_colDrive; // Coil pattern for popped entry
  logic irqSet; // Raise the interrupt line
  logic irqDrop; // Force the interrupt line low

  //////////////////////////////////////////////////////////////////////////////
  // Carrier reset pin synchroniser
  bit_sync u_reset_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .din(carrierResetReq),
    .dout(carrierReset)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command queue
  // eight-deep queue
  cmd_queue u_queue
  (
    .clk(clk),
    .rst_b(rst_b),
    .push(accept),
    .pushEntry(newEntry),
    .pop(popHead),
    .headEntry(head),
    .empty(qEmpty),
    .full(qFull)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  // low four bits used
  assign wrCols = writeData[relay_matrix_pkg::COLS-1:0];
  assign curRow = rowState[writeRow];
  assign accept = rowWrite && !qFull && !carrierReset;
  assign next_row = writeIsClose ? (curRow | wrCols) : (curRow & wrCols);
  assign newEntry = {writeIsClose, writeRow, wrCols};
  assign initWrite = accept && !writeIsClose && powerEnable && (wrCols == '0);

  //////////////////////////////////////////////////////////////////////////////
  // Head decode and engine control
  assign headCols = head[relay_matrix_pkg::ENTRY_ROW_LSB-1:relay_matrix_pkg::ENTRY_COL_LSB];
  assign headRow = head[relay_matrix_pkg::ENTRY_KIND_BIT-1:relay_matrix_pkg::ENTRY_ROW_LSB];
  assign headClose = head[relay_matrix_pkg::ENTRY_KIND_BIT];
  assign timerDone = (timer == '0);
  assign popHead = !qEmpty && (state == relay_matrix_pkg::IDLE || timerDone);
  assign lastDone = (state == relay_matrix_pkg::DRIVE) && timerDone && qEmpty;
  // Close drives ones; open drives the zero columns
  assign next_colDrive = headClose ? headCols : ~headCols;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_state = state;
    case (state)
      relay_matrix_pkg::IDLE:
      begin
        if (popHead)
        begin
          next_state = relay_matrix_pkg::DRIVE;
        end
      end
      relay_matrix_pkg::DRIVE:
      begin
        if (lastDone)
        begin
          next_state = relay_matrix_pkg::IDLE;
        end
      end
      default:
      begin
        next_state = relay_matrix_pkg::IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine state and timer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= relay_matrix_pkg::IDLE;
      timer <= '0;
    end
    // Every pop reloads the full drive time, chained or not
    else if (popHead)
    begin
      state <= next_state;
      timer <= relay_matrix_pkg::TIMER_W'(relay_matrix_pkg::DRIVE_CYCLES - 1);
    end
    else
    begin
      state <= next_state;
      if (!timerDone)
      begin
        timer <= timer - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coil drive outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rowDrive <= '0;
      colDrive <= '0;
      driveClose <= 1'b0;
    end
    else if (popHead)
    begin
      rowDrive <= relay_matrix_pkg::ROWS'(1) << headRow;
      colDrive <= powerEnable ? next_colDrive : '0;
      driveClose <= headClose;
    end
    // Last operation ended: release every coil
    else if (lastDone)
    begin
      rowDrive <= '0;
      colDrive <= '0;
      driveClose <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Readback store
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int r = 0; r < relay_matrix_pkg::ROWS; r++)
      begin
        rowState[r] <= relay_matrix_pkg::ROW_RESET;
      end
    end
    else if (carrierReset)
    begin
      for (int r = 0; r < relay_matrix_pkg::ROWS; r++)
      begin
        rowState[r] <= relay_matrix_pkg::ROW_RESET;
      end
    end
    else if (accept)
    begin
      rowState[writeRow] <= next_row;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Initialisation tracking
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rowOpened <= '0;
      initDone <= 1'b0;
    end
    else if (carrierReset)
    begin
      rowOpened <= '0;
      initDone <= 1'b0;
    end
    else
    begin
      if (initWrite)
      begin
        rowOpened[writeRow] <= 1'b1;
      end
      if (rowOpened == relay_matrix_pkg::INIT_ALL)
      begin
        initDone <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Readback register, one cycle behind the row select
  // Bits above the columns read as zero
  // one value per row
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readData <= '0; // Nothing stored after reset
    end
    else
    begin
      readData <= relay_matrix_pkg::DATA_W'(rowState[readRow]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Queue flags, registered so the outputs come from flops
  // One cycle behind the queue's own flags
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      queueEmpty <= 1'b1; // Queue starts empty
      queueFull <= 1'b0;
    end
    else
    begin
      queueEmpty <= qEmpty;
      queueFull <= qFull;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Driver power switch
  // Carrier reset forces the switch open while it lasts
  // power follows enable, off at reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      driverPower <= 1'b0; // Off after power-on
    end
    else
    begin
      driverPower <= powerEnable && !carrierReset;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt set and clear terms
  // Allow bit low or carrier reset holds the line quiet
  assign irqDrop = !irqAllowBit || carrierReset;
  assign irqSet = lastDone;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt line
  // A write landing on the final expiry still raises the line; the pop that
  // follows drops it, so the line never stands while a row is driven
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq <= 1'b0;
    end
    else if (irqDrop)
    begin
      irq <= 1'b0;
    end
    else if (irqSet)
    begin
      irq <= 1'b1;
    end
    // New work withdraws the request
    else if (accept || popHead)
    begin
      irq <= 1'b0;
    end
  end

endmodule : relay_matrix_command_queue

// ===== rtl/relay_matrix_pkg.sv
package relay_matrix_pkg;

  // Matrix geometry
  localparam int ROWS = 4;
  localparam int COLS = 4;
  localparam int ROW_IDX_W = 2;
  localparam int DATA_W = 16;

  // Command queue depth and pointer width
  localparam int QUEUE_DEPTH = 8;
  localparam int QPTR_W = 3;
  localparam int QCOUNT_W = 4;

  // Queue entry layout: {isClose, row, cols}
  localparam int ENTRY_W = 1 + ROW_IDX_W + COLS;
  localparam int ENTRY_COL_LSB = 0;
  localparam int ENTRY_ROW_LSB = COLS;
  localparam int ENTRY_KIND_BIT = COLS + ROW_IDX_W;

  // Relay drive timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int DRIVE_TIME_MS = 8;
  localparam int DRIVE_CYCLES = CLK_FREQ_HZ / 1000 * DRIVE_TIME_MS;
  localparam int TIMER_W = 17;

  // Reset values
  localparam logic [COLS-1:0] ROW_RESET = 4'h0;
  localparam logic [COLS-1:0] INIT_ALL = 4'hF;

  // Drive engine states
  typedef enum logic [0:0] {IDLE, DRIVE} drive_state_type;

endpackage : relay_matrix_pkg

// ===== rtl/bit_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for one asynchronous level
module bit_sync
(
  input wire logic clk,   // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic din,   // Asynchronous level
  output logic dout       // Synchronised level
);

  logic stage1; // First flop, read only by second

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage capture
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule : bit_sync

// ===== rtl/cmd_queue.sv
`timescale 1ns/1ns
// First-in-first-out store of relay row operations, flip-flop storage
module cmd_queue
(
  input wire logic clk,                                         // System clock
  input wire logic rst_b,                                       // Async reset, active low
  input wire logic push,                                        // Append entry
  input wire logic [relay_matrix_pkg::ENTRY_W-1:0] pushEntry,   // Entry to append
  input wire logic pop,                                         // Remove head
  output logic [relay_matrix_pkg::ENTRY_W-1:0] headEntry,       // Oldest entry
  output logic empty,                                           // No entry held
  output logic full                                             // All slots used
);

  logic [relay_matrix_pkg::ENTRY_W-1:0] store [relay_matrix_pkg::QUEUE_DEPTH]; // Slots
  logic [relay_matrix_pkg::QPTR_W-1:0] wrPtr; // Write index
  logic [relay_matrix_pkg::QPTR_W-1:0] rdPtr; // Read index
  logic [relay_matrix_pkg::QCOUNT_W-1:0] count; // Entries held
  logic doPush; // Push accepted
  logic doPop; // Pop accepted

  assign doPush = push && (count != relay_matrix_pkg::QCOUNT_W'(relay_matrix_pkg::QUEUE_DEPTH));
  assign doPop = pop && (count != '0);
  assign headEntry = store[rdPtr];
  assign empty = (count == '0);
  assign full = (count == relay_matrix_pkg::QCOUNT_W'(relay_matrix_pkg::QUEUE_DEPTH));

  //////////////////////////////////////////////////////////////////////////////
  // Slot write
  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      store[wrPtr] <= pushEntry;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointers and count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
        count <= count + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : cmd_queue

// ===== tb/relay_matrix_checker.sv
`timescale 1ns/1ns
// Port-level checks of the relay command queue
module relay_matrix_checker
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic rowWrite, // Write strobe
  input wire logic writeIsClose, // Close or open
  input wire logic [1:0] writeRow, // Row written
  input wire logic [15:0] writeData, // Data written
  input wire logic [1:0] readRow, // Row read
  input wire logic irqAllowBit, // Interrupt allow
  input wire logic powerEnable, // Power enable
  input wire logic carrierResetReq, // Carrier reset
  input wire logic [15:0] readData, // Readback
  input wire logic queueEmpty, // Empty flag
  input wire logic queueFull, // Full flag
  input wire logic initDone, // Init flag
  input wire logic irq, // Interrupt
  input wire logic driverPower, // Power switch
  input wire logic [3:0] rowDrive, // Row driven
  input wire logic [3:0] colDrive, // Columns driven
  input wire logic driveClose // Close coils
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  upper_zero_a: assert property (readData[15:4] == 12'h000)
    else $error("readback upper bits set");
  one_row_a: assert property ($onehot0(rowDrive))
    else $error("more than one row driven");
  flag_excl_a: assert property (!(queueFull && queueEmpty))
    else $error("queue full and empty together");
  irq_allow_a: assert property (irq |-> $past(irqAllowBit))
    else $error("interrupt without allow bit");
  irq_idle_a: assert property (irq |-> rowDrive == 4'h0)
    else $error("interrupt while driving");
  irq_last_a: assert property ($rose(irq) |-> queueEmpty && $past(|rowDrive))
    else $error("interrupt not after last operation");
  power_follow_a: assert property (driverPower |-> $past(powerEnable))
    else $error("driver power without enable");
  drive_hold_a: assert property ($rose(|rowDrive) |-> (|rowDrive) [*8])
    else $error("drive dropped early");
  init_write_a: assert property ($rose(initDone) |->
    $past(rowWrite) || $past(rowWrite, 2) || $past(rowWrite, 3))
    else $error("init flag set without writes");
endmodule : relay_matrix_checker

// ===== tb/carrier_model.sv
`timescale 1ns/1ns
// Carrier side: row register writes and readback selection
module carrier_model
(
  input wire logic clk, // Clock
  output logic rowWrite, // Write strobe
  output logic writeIsClose, // Close or open
  output logic [1:0] writeRow, // Row written
  output logic [15:0] writeData, // Data written
  output logic [1:0] readRow // Row read
);
  // Idle bus at time zero
  initial
  begin
    rowWrite = 1'b0;
    writeIsClose = 1'b0;
    writeRow = 2'h0;
    writeData = 16'hA5A5;
    readRow = 2'h0;
  end
  // One write per cycle; a following call keeps the strobe up
  task put(input logic close, input logic [1:0] row, input logic [15:0] data);
    @(negedge clk);
    rowWrite = 1'b1;
    writeIsClose = close;
    writeRow = row;
    writeData = data;
  endtask : put
  // Released data lines show the inverse, never a stale value
  task idle();
    @(negedge clk);
    rowWrite = 1'b0;
    writeData = ~writeData;
  endtask : idle
  // Readback row select
  task sel(input logic [1:0] row);
    @(negedge clk);
    readRow = row;
  endtask : sel
endmodule : carrier_model

// ===== tb/relay_matrix_command_queue_test.sv
`timescale 1ns/1ns
// Bench for the relay command queue
module relay_matrix_command_queue_test;
  logic clk, rst_b, irqAllowBit, powerEnable, carrierResetReq; // Bench inputs
  logic rowWrite, writeIsClose; // Carrier strobes
  logic [1:0] writeRow, readRow; // Carrier rows
  logic [15:0] writeData, readData; // Data
  logic queueEmpty, queueFull, initDone, irq, driverPower, driveClose; // Flags
  logic [3:0] rowDrive, colDrive; // Drive outputs
  int errors, nCompared, cycles, n; // Counters
  relay_matrix_command_queue relay_matrix_command_queue_i (.clk(clk), .rst_b(rst_b),
    .rowWrite(rowWrite), .writeIsClose(writeIsClose), .writeRow(writeRow),
    .writeData(writeData), .readRow(readRow), .irqAllowBit(irqAllowBit),
    .powerEnable(powerEnable), .carrierResetReq(carrierResetReq), .readData(readData),
    .queueEmpty(queueEmpty), .queueFull(queueFull), .initDone(initDone), .irq(irq),
    .driverPower(driverPower), .rowDrive(rowDrive), .colDrive(colDrive),
    .driveClose(driveClose));
  carrier_model carrier_model_i (.clk(clk), .rowWrite(rowWrite), .writeIsClose(writeIsClose),
    .writeRow(writeRow), .writeData(writeData), .readRow(readRow));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 85000)
    begin
      errors++;
      end_sim();
    end
  end
  // Compare, count, report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Select a row and compare its readback
  task rd(input logic [1:0] row, input logic [15:0] exp);
    carrier_model_i.sel(row);
    repeat (3) @(negedge clk);
    chk(readData, exp);
  endtask : rd
  task end_sim();
    $display("compared %0d, errors %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_b, irqAllowBit, powerEnable, carrierResetReq} = 4'h0;
    {errors, nCompared, cycles} = 0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk({initDone, driverPower, queueEmpty, readData}, 32'h0001_0000);
    // Unpowered write still reads back, coils stay dead
    carrier_model_i.put(1'b1, 2'h3, 16'h000A);
    carrier_model_i.idle();
    rd(2'h3, 16'h000A);
    chk({rowDrive, colDrive}, 8'h80);
    powerEnable = 1'b1;
    for (int r = 0; r < 4; r++)
      carrier_model_i.put(1'b0, r[1:0], 16'h0000);
    carrier_model_i.idle();
    repeat (4) @(negedge clk);
    chk(initDone, 1'b1);
    chk({driverPower, initDone}, 2'h3);
    // Close, open, close on row 1; fill queue to eight, last write refused
    carrier_model_i.put(1'b1, 2'h1, 16'hFFF5);
    carrier_model_i.put(1'b0, 2'h1, 16'h0006);
    carrier_model_i.put(1'b1, 2'h1, 16'h0002);
    carrier_model_i.put(1'b1, 2'h2, 16'h0003);
    carrier_model_i.put(1'b1, 2'h3, 16'h0005);
    carrier_model_i.idle();
    chk({queueFull, queueEmpty}, 2'h2);
    rd(2'h1, 16'h0006);
    rd(2'h2, 16'h0003);
    chk(queueEmpty, 1'b0);
    rd(2'h3, 16'h0000);
    // Mid-run reset wipes readback and init flag
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(2'h1, 16'h0000);
    chk({initDone, queueEmpty}, 2'h1);
    // One powered close, timed, then interrupt
    irqAllowBit = 1'b1;
    carrier_model_i.put(1'b1, 2'h2, 16'h0009);
    carrier_model_i.idle();
    n = 0;
    while (rowDrive === 4'h0 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk({rowDrive, colDrive, driveClose}, 9'h093);
    n = 0;
    while (rowDrive !== 4'h0 && n < 82000)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, relay_matrix_pkg::DRIVE_CYCLES);
    chk({irq, queueEmpty}, 2'h3);
    rd(2'h2, 16'h0009);
    irqAllowBit = 1'b0;
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    // Carrier reset clears readback
    carrierResetReq = 1'b1;
    repeat (4) @(negedge clk);
    chk(driverPower, 1'b0);
    @(negedge clk);
    carrierResetReq = 1'b0;
    rd(2'h2, 16'h0000);
    // Open operation drives the zero columns of its row
    carrier_model_i.put(1'b0, 2'h0, 16'h0003);
    carrier_model_i.idle();
    @(negedge clk);
    chk({rowDrive, colDrive, driveClose}, 9'h038);
    end_sim();
  end
endmodule : relay_matrix_command_queue_test

bind relay_matrix_command_queue relay_matrix_checker relay_matrix_checker_i (.clk(clk),
  .rst_b(rst_b), .rowWrite(rowWrite), .writeIsClose(writeIsClose), .writeRow(writeRow),
  .writeData(writeData), .readRow(readRow), .irqAllowBit(irqAllowBit),
  .powerEnable(powerEnable), .carrierResetReq(carrierResetReq), .readData(readData),
  .queueEmpty(queueEmpty), .queueFull(queueFull), .initDone(initDone), .irq(irq),
  .driverPower(driverPower), .rowDrive(rowDrive), .colDrive(colDrive),
  .driveClose(driveClose));
